// [smps_pkg.sv]
// shared constants for the serial mux port status block
// Notes on behaviour
// - receiver posts two-bit flag per received character
// - parity flagged only when not inhibited
// - overload when previous character not yet stored
// - missing stop bit flags break or framing
// - any error flag sets input-done and interrupt
// - simultaneous errors keep the highest flag code
// - busy output during echo sets not-echoed, done
// - allocation option makes bit 6 address msb
// - storing while input-done set flags service overload
// - allocation option: bit 7 ors both conditions
// - done-causing character lands in upper byte
// - buffered characters skip control word except full
// - mid-word buffer end posts last word's right byte
// - single or control output sets done on fetch
// - auto output sets done on last fetch
// - special character ends auto output, sets done
// - device status change always sets output-done
// - interrupt raised together with output-done
// - no output while output-done stays set
// - output-done set suppresses all port interrupts
// - interrupting characters are not echoed, except full
package smps_pkg;
    // register map, byte addresses
    localparam logic [7:0] A_PORT_STRIDE = 8'h08;
    localparam logic [7:0] A_OCW_OFS = 8'h04;
    localparam logic [7:0] A_CFG = 8'h80;
    localparam logic [7:0] A_STAT = 8'h84;
    localparam logic [15:0] CW_RST = 16'h0000;
    localparam logic CFG_RST = 1'b0;
    // input control word fields
    localparam int ICW_DONE = 0;
    localparam int ICW_MODE_LO = 1;
    localparam int ICW_MODE_HI = 2;
    localparam int ICW_SPEC = 3;
    localparam int ICW_FLAG_LO = 4;
    localparam int ICW_FLAG_HI = 5;
    localparam int ICW_NOECHO = 6;
    localparam int ICW_SVC = 7;
    localparam int CW_CHAR_LO = 8;
    localparam int CW_CHAR_HI = 15;
    // output control word fields
    localparam int OCW_DONE = 0;
    localparam int OCW_MODE_LO = 1;
    localparam int OCW_SPEC = 3;
    localparam int OCW_STAT = 4;
    localparam int OCW_PREV = 5;
    localparam int OCW_RSV = 6;
    localparam int OCW_CHG = 7;
    localparam int OCW_NOPAR = 8;
    // receiver flag codes
    localparam logic [1:0] FLG_NORM = 2'h0;
    localparam logic [1:0] FLG_PAR = 2'h1;
    localparam logic [1:0] FLG_OVL = 2'h2;
    localparam logic [1:0] FLG_BRK = 2'h3;
    // modes
    localparam logic [1:0] IN_SINGLE = 2'h0;
    localparam logic [1:0] IN_ECHO = 2'h3;
    localparam logic [1:0] OUT_NONE = 2'h0;
    localparam logic [1:0] OUT_AUTO = 2'h1;
    localparam logic [1:0] OUT_CTRL = 2'h2;
    localparam logic [1:0] OUT_SINGLE = 2'h3;
    // bus codes
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam int NPORT_DEF = 4;
endpackage

// [smps_rx_flags.sv]
// receiver flag priority encoder
`timescale 1ns/1ps
module smps_rx_flags
    import smps_pkg::*;
(
    // error conditions
    input wire logic parity_err,
    input wire logic parity_off,
    input wire logic overload,
    input wire logic no_stop,
    // encoded flag
    output logic [1:0] flag
);
    wire par_hit = parity_err && !parity_off;
    // highest code wins when several coincide
    assign flag = no_stop ? FLG_BRK :
                  overload ? FLG_OVL :
                  par_hit ? FLG_PAR : FLG_NORM;
endmodule // smps_rx_flags

// [smps_out_done.sv]
// output-done set conditions for one port
`timescale 1ns/1ps
module smps_out_done
    import smps_pkg::*;
(
    // control word state
    input wire logic [1:0] mode,
    input wire logic spec_req,
    input wire logic done,
    // port events
    input wire logic fetch,
    input wire logic last,
    input wire logic special_sent,
    input wire logic status_chg,
    // results
    output logic done_set,
    output logic irq,
    output logic tx_allow
);
    wire direct = (mode == OUT_SINGLE) || (mode == OUT_CTRL);
    wire is_auto = mode == OUT_AUTO;
    wire set_fetch = fetch && direct;
    wire set_last = fetch && last && is_auto;
    // done halts auto output until the program reloads
    wire set_spec = special_sent && spec_req && is_auto;
    assign done_set = set_fetch || set_last || set_spec
                      || status_chg;
    assign irq = done_set && !done;
    assign tx_allow = (mode != OUT_NONE) && !done;
endmodule // smps_out_done

// [smps_port_status.sv]
// per-port control word status engine with ahb-lite access
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module smps_port_status
    import smps_pkg::*;
#(
    parameter int NPORT = NPORT_DEF,
    parameter int PW = 2
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // receiver side
    input wire logic rx_valid,
    input wire logic [PW-1:0] rx_port,
    input wire logic [7:0] rx_char,
    input wire logic rx_parity_err,
    input wire logic rx_no_stop,
    input wire logic rx_special,
    input wire logic rx_buf_full,
    input wire logic rx_mid_word,
    input wire logic [7:0] rx_last_byte,
    // data channel
    input wire logic dch_grant,
    output logic dch_wr,
    output logic [PW-1:0] dch_port,
    output logic [15:0] dch_icw,
    output logic buf_wr,
    output logic [7:0] buf_char,
    output logic echo_req,
    // transmit side
    input wire logic [NPORT-1:0] out_busy,
    input wire logic [NPORT-1:0] tx_fetch,
    input wire logic [NPORT-1:0] tx_last,
    input wire logic [NPORT-1:0] tx_special_sent,
    input wire logic [NPORT-1:0] dev_status,
    output logic [NPORT-1:0] tx_allow,
    // port interrupts
    output logic [NPORT-1:0] port_irq
);
    // control words and pending receive state
    logic [15:0] icw_reg [NPORT];
    logic [15:0] ocw_reg [NPORT];
    logic [15:0] icw_sw [NPORT];
    logic pend_v_reg [NPORT];
    logic [7:0] pend_char_reg [NPORT];
    logic [1:0] pend_flag_reg [NPORT];
    logic pend_spec_reg [NPORT];
    logic pend_full_reg [NPORT];
    logic pend_mid_reg [NPORT];
    logic [7:0] pend_lb_reg [NPORT];
    logic irq_reg [NPORT];
    logic opt_reg;
    logic dp_wr_reg;
    logic [7:0] dp_addr_reg;
    logic [31:0] hrdata_reg;
    logic dch_wr_reg;
    logic [PW-1:0] dch_port_reg;
    logic [15:0] dch_icw_reg;
    logic buf_wr_reg;
    logic [7:0] buf_char_reg;
    logic echo_reg;
    logic [PW-1:0] lpp_reg;
    logic [PW-1:0] lrx_reg;
    logic [PW-1:0] post_port;
    logic post_any;
    logic [31:0] pend_vec;
    logic [1:0] rx_flag;

    // bus front end: zero wait states, always okay
    wire take = hsel && hready && htrans[1];
    wire word_ok = hsize == HSIZE_WORD;
    wire [PW-1:0] rd_idx = haddr[PW+2:3];
    wire rd_in_port = haddr[7:3] < 5'(NPORT);
    wire [15:0] rd_cw = haddr[2] ? ocw_reg[rd_idx] : icw_reg[rd_idx];
    wire [31:0] stat_word = pend_vec | (32'(tx_allow) << 16);
    wire [31:0] rd_word = rd_in_port ? {16'h0000, rd_cw} :
                          (haddr == A_CFG) ? {31'h00000000, opt_reg} :
                          (haddr == A_STAT) ? stat_word : 32'h00000000;
    wire wr_go = dp_wr_reg;
    wire [PW-1:0] wr_idx = dp_addr_reg[PW+2:3];
    wire wr_in_port = dp_addr_reg[7:3] < 5'(NPORT);
    wire wr_ocw = dp_addr_reg[2];
    wire wr_cfg = wr_go && (dp_addr_reg == A_CFG);

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
            opt_reg <= CFG_RST;
        end
        else
        begin
            dp_wr_reg <= take && hwrite && word_ok;
            if (take)
                dp_addr_reg <= haddr;
            if (take && !hwrite)
                hrdata_reg <= rd_word;
            if (wr_cfg)
                opt_reg <= hwdata[0];
        end
    end

    // pending vector for the status word
    always_comb
    begin
        pend_vec = 32'h00000000;
        for (int i = 0; i < NPORT; i++)
            pend_vec[i] = pend_v_reg[i];
    end

    // lowest pending port gets the next channel cycle
    always_comb
    begin
        post_port = '0;
        post_any = 1'b0;
        for (int i = NPORT - 1; i >= 0; i--)
            if (pend_v_reg[i])
            begin
                post_port = PW'(i);
                post_any = 1'b1;
            end
    end
    wire post = post_any && dch_grant;

    // receive flag for the arriving character
    wire rx_posting = post && (post_port == rx_port);
    wire rx_ovl = pend_v_reg[rx_port] && !rx_posting;
    smps_rx_flags u_flags (
        .parity_err(rx_parity_err),
        .parity_off(ocw_reg[rx_port][OCW_NOPAR]),
        .overload(rx_ovl),
        .no_stop(rx_no_stop),
        .flag(rx_flag)
    );

    // posting of the selected port's input control word
    wire [15:0] pc = icw_sw[post_port];
    wire [1:0] pmode = pc[ICW_MODE_HI:ICW_MODE_LO];
    wire [1:0] pflag = pend_flag_reg[post_port];
    wire pauto = pc[ICW_MODE_HI];
    wire perr = pflag != FLG_NORM;
    wire pspec = pend_spec_reg[post_port] && pc[ICW_SPEC];
    wire pfull = pend_full_reg[post_port];
    wire echo_try = (pmode == IN_ECHO) && !perr && !pspec;
    wire noecho = echo_try && out_busy[post_port];
    wire done_cause = (pmode == IN_SINGLE) || !pauto || perr || pspec
                      || pfull || noecho;
    wire svc = pc[ICW_DONE];
    wire pmid = pfull && pend_mid_reg[post_port];
    wire [7:0] pchar = pmid ? pend_lb_reg[post_port]
                            : pend_char_reg[post_port];
    wire to_buf = pauto && (!done_cause || pfull);
    wire [15:0] post_icw;
    assign post_icw[ICW_DONE] = pc[ICW_DONE] | done_cause;
    assign post_icw[ICW_SPEC:ICW_MODE_LO] = pc[ICW_SPEC:ICW_MODE_LO];
    assign post_icw[ICW_FLAG_HI:ICW_FLAG_LO] = pflag;
    // with allocation the bit is address, left as software set it
    assign post_icw[ICW_NOECHO] = opt_reg ? pc[ICW_NOECHO]
                                  : (pc[ICW_NOECHO] | noecho);
    assign post_icw[ICW_SVC] = pc[ICW_SVC] | svc
                               | (opt_reg & noecho);
    assign post_icw[CW_CHAR_HI:CW_CHAR_LO] = done_cause ? pchar
        : pc[CW_CHAR_HI:CW_CHAR_LO];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dch_wr_reg <= 1'b0;
            dch_port_reg <= '0;
            dch_icw_reg <= CW_RST;
            buf_wr_reg <= 1'b0;
            buf_char_reg <= 8'h00;
            echo_reg <= 1'b0;
            lpp_reg <= '0;
            lrx_reg <= '0;
        end
        else
        begin
            dch_wr_reg <= post;
            dch_port_reg <= post_port;
            dch_icw_reg <= post_icw;
            buf_wr_reg <= post && to_buf;
            buf_char_reg <= pend_char_reg[post_port];
            echo_reg <= post && echo_try && !out_busy[post_port];
            lpp_reg <= post_port;
            lrx_reg <= rx_port;
        end
    end
    assign dch_wr = dch_wr_reg;
    assign dch_port = dch_port_reg;
    assign dch_icw = dch_icw_reg;
    assign buf_wr = buf_wr_reg;
    assign buf_char = buf_char_reg;
    assign echo_req = echo_reg;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        wire sw_hit = wr_go && wr_in_port && (wr_idx == PW'(p));
        wire sw_icw = sw_hit && !wr_ocw;
        wire sw_ocw = sw_hit && wr_ocw;
        wire posted = post && (post_port == PW'(p));
        wire rx_hit = rx_valid && (rx_port == PW'(p));
        wire chg = dev_status[p] != ocw_reg[p][OCW_STAT];
        wire [15:0] ocw_sw = sw_ocw ? hwdata[15:0] : ocw_reg[p];
        wire [15:0] ocw_nx;
        wire in_irq = posted && done_cause;
        logic dset;
        logic oirq;
        // hardware updates land on top of software writes
        assign icw_sw[p] = sw_icw ? hwdata[15:0] : icw_reg[p];
        smps_out_done u_done (
            .mode(ocw_reg[p][OCW_MODE_LO+1:OCW_MODE_LO]),
            .spec_req(ocw_reg[p][OCW_SPEC]),
            .done(ocw_reg[p][OCW_DONE]),
            .fetch(tx_fetch[p]),
            .last(tx_last[p]),
            .special_sent(tx_special_sent[p]),
            .status_chg(chg),
            .done_set(dset),
            .irq(oirq),
            .tx_allow(tx_allow[p])
        );
        assign ocw_nx[OCW_DONE] = ocw_sw[OCW_DONE] | dset;
        assign ocw_nx[OCW_SPEC:OCW_MODE_LO] = ocw_sw[OCW_SPEC:OCW_MODE_LO];
        assign ocw_nx[OCW_STAT] = dev_status[p];
        assign ocw_nx[OCW_PREV] = ocw_reg[p][OCW_STAT];
        assign ocw_nx[OCW_RSV] = ocw_sw[OCW_RSV];
        assign ocw_nx[OCW_CHG] = ocw_sw[OCW_CHG] | chg;
        assign ocw_nx[CW_CHAR_HI:CW_CHAR_LO] =
            ocw_sw[CW_CHAR_HI:CW_CHAR_LO];
        assign port_irq[p] = irq_reg[p];

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                icw_reg[p] <= CW_RST;
                ocw_reg[p] <= CW_RST;
                irq_reg[p] <= 1'b0;
            end
            else
            begin
                icw_reg[p] <= posted ? post_icw : icw_sw[p];
                ocw_reg[p] <= ocw_nx;
                // done gates input and output interrupts alike
                irq_reg[p] <= (in_irq || oirq)
                              && !ocw_reg[p][OCW_DONE];
            end
        end

        // a new arrival replaces the held one, flag included, with its own rx_flag
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                pend_v_reg[p] <= 1'b0;
                pend_char_reg[p] <= 8'h00;
                pend_flag_reg[p] <= FLG_NORM;
                pend_spec_reg[p] <= 1'b0;
                pend_full_reg[p] <= 1'b0;
                pend_mid_reg[p] <= 1'b0;
                pend_lb_reg[p] <= 8'h00;
            end
            else if (rx_hit)
            begin
                pend_v_reg[p] <= 1'b1;
                pend_char_reg[p] <= rx_char;
                pend_flag_reg[p] <= rx_flag;
                pend_spec_reg[p] <= rx_special;
                pend_full_reg[p] <= rx_buf_full;
                pend_mid_reg[p] <= rx_mid_word;
                pend_lb_reg[p] <= rx_last_byte;
            end
            else if (posted)
                pend_v_reg[p] <= 1'b0;
        end

        property p_fetch_done;
            tx_fetch[p] && (ocw_reg[p][2:1] == OUT_SINGLE)
                |=> ocw_reg[p][OCW_DONE];
        endproperty
        a_fetch_done: assert property (p_fetch_done)
            else $error("fetch did not set output done");

        property p_irq_hold;
            ocw_reg[p][OCW_DONE] |=> !port_irq[p];
        endproperty
        a_irq_hold: assert property (p_irq_hold)
            else $error("interrupt while output done set");
    end

    property p_brk;
        rx_valid && rx_no_stop |=> pend_flag_reg[lrx_reg] == FLG_BRK;
    endproperty
    a_brk: assert property (p_brk)
        else $error("missing stop bit not flagged");

    property p_par;
        rx_valid && rx_parity_err && ocw_reg[rx_port][OCW_NOPAR]
            |-> rx_flag != FLG_PAR;
    endproperty
    a_par: assert property (p_par)
        else $error("parity flagged while inhibited");

    property p_ovl;
        rx_valid && rx_ovl && !rx_no_stop |-> rx_flag == FLG_OVL;
    endproperty
    a_ovl: assert property (p_ovl)
        else $error("overload not flagged");

    property p_err_done;
        post && perr |=> icw_reg[lpp_reg][ICW_DONE] && dch_wr;
    endproperty
    a_err_done: assert property (p_err_done)
        else $error("error did not set input done");

    property p_in_irq;
        post && done_cause && !ocw_reg[post_port][OCW_DONE]
            |=> port_irq[lpp_reg];
    endproperty
    a_in_irq: assert property (p_in_irq)
        else $error("input done without interrupt");

    property p_char;
        post && done_cause |=>
            icw_reg[lpp_reg][CW_CHAR_HI:CW_CHAR_LO] == $past(pchar);
    endproperty
    a_char: assert property (p_char)
        else $error("character not posted");

    property p_noecho;
        post && noecho && !opt_reg |=> icw_reg[lpp_reg][ICW_NOECHO]
            && !echo_req;
    endproperty
    a_noecho: assert property (p_noecho)
        else $error("not-echoed missing");

    property p_or7;
        post && opt_reg && noecho |=> icw_reg[lpp_reg][ICW_SVC];
    endproperty
    a_or7: assert property (p_or7)
        else $error("bit 7 not set by not-echoed");
endmodule // smps_port_status

// [smps_chan_model.sv]
// data channel model that hands memory cycles to the status block
`timescale 1ns/1ps
module smps_chan_model
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pacing from the bench
    input wire logic stall,
    input wire logic slow,
    // data channel
    input wire logic dch_wr,
    output logic dch_grant
);
    logic phase_reg;
    int posts;
    // slow mode grants every other cycle, like a busy channel
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            phase_reg <= 1'b0;
        else
            phase_reg <= ~phase_reg;
    end
    // no cycles granted while stalled or in reset
    assign dch_grant = hresetn & ~stall & (~slow | phase_reg);
    always @(posedge hclk)
    begin
        if (dch_wr === 1'b1)
            posts++;
    end
endmodule // smps_chan_model

// [tb_top.sv]
// self-checking bench for the port status block
`timescale 1ns/1ps
module tb_top
    import smps_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic rx_valid, rx_parity_err, rx_no_stop, rx_special;
    logic rx_buf_full, rx_mid_word, dch_grant, dch_wr, buf_wr, echo_req;
    logic [1:0] rx_port, dch_port;
    logic [7:0] rx_char, rx_last_byte, buf_char;
    logic [15:0] dch_icw;
    logic [3:0] out_busy, tx_fetch, tx_last, tx_special_sent, dev_status;
    logic [3:0] tx_allow, port_irq;
    logic stall, slow;
    int fail_count, checked, echo_cnt;
    int irq_cnt [4];

    smps_port_status #(.NPORT(4), .PW(2)) smps_port_status_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_valid(rx_valid), .rx_port(rx_port),
        .rx_char(rx_char), .rx_parity_err(rx_parity_err),
        .rx_no_stop(rx_no_stop), .rx_special(rx_special),
        .rx_buf_full(rx_buf_full), .rx_mid_word(rx_mid_word),
        .rx_last_byte(rx_last_byte), .dch_grant(dch_grant), .dch_wr(dch_wr),
        .dch_port(dch_port), .dch_icw(dch_icw), .buf_wr(buf_wr),
        .buf_char(buf_char), .echo_req(echo_req), .out_busy(out_busy),
        .tx_fetch(tx_fetch), .tx_last(tx_last),
        .tx_special_sent(tx_special_sent), .dev_status(dev_status),
        .tx_allow(tx_allow), .port_irq(port_irq));
    smps_chan_model smps_chan_model_inst (.hclk(hclk), .hresetn(hresetn),
        .stall(stall), .slow(slow), .dch_wr(dch_wr), .dch_grant(dch_grant));

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        for (int i = 0; i < 4; i++)
            if (port_irq[i] === 1'b1)
                irq_cnt[i]++;
        if (echo_req === 1'b1)
            echo_cnt++;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic hang();
        fail_count++;
        $display("CHECK FAILED %0t wait ran out", $time);
        stop_test();
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t flag %b want %b", $time, got, exp);
        end
    endtask
    // hreadyout is the bus hready; wait on it without assuming latency
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
                hang();
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk32(r & m, e);
    endtask
    // f holds mid-word, buffer-full, no-stop and parity error
    task automatic rx(input logic [1:0] p, input logic [7:0] c,
                      input logic [3:0] f);
        rx_valid <= 1'b1;
        rx_port <= p;
        rx_char <= c;
        {rx_mid_word, rx_buf_full, rx_no_stop, rx_parity_err} <= f;
        @(posedge hclk);
        rx_valid <= 1'b0;
        {rx_mid_word, rx_buf_full, rx_no_stop, rx_parity_err} <= 4'h0;
    endtask
    // waits for a control word post, or a buffer write when bw is set
    task automatic wait_post(input logic bw, input logic [1:0] p,
                             input logic [15:0] e);
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            #1;
            n++;
            if (n > 60)
                hang();
        end
        while (bw ? buf_wr !== 1'b1 : !(dch_wr === 1'b1 && dch_port === p));
        chk32({16'h0, bw ? {8'h0, buf_char} : dch_icw}, {16'h0, e});
        @(posedge hclk);
    endtask
    // sel 0 plain fetch, 1 last fetch, 2 special sent
    task automatic tx_evt(input int sel, input int p);
        tx_fetch[p] <= (sel < 2);
        tx_last[p] <= (sel == 1);
        tx_special_sent[p] <= (sel == 2);
        @(posedge hclk);
        tx_fetch <= 4'h0;
        tx_last <= 4'h0;
        tx_special_sent <= 4'h0;
        repeat (3) @(posedge hclk);
    endtask

    task automatic t_receive();
        int i0, p0;
        i0 = irq_cnt[0];
        p0 = smps_chan_model_inst.posts;
        rd_chk(8'h40, 32'h0, 32'hFFFF_FFFF);
        chk1(hresp, HRESP_OKAY);
        rx(2'd0, 8'h41, 4'h0);
        wait_post(1'b0, 2'd0, 16'h4101);
        rd_chk(8'h00, 32'h4101, 32'hFFFF_FFFF);
        chk32(32'(irq_cnt[0] - i0), 32'h1);
        rx(2'd0, 8'h42, 4'h1);
        wait_post(1'b0, 2'd0, 16'h4291);
        slow <= 1'b1;
        wr(8'h00, 32'h0);
        rx(2'd0, 8'h00, 4'h3);
        wait_post(1'b0, 2'd0, 16'h0031);
        wr(8'h04, 32'h0100);
        wr(8'h00, 32'h0);
        rx(2'd0, 8'h55, 4'h1);
        wait_post(1'b0, 2'd0, 16'h5501);
        wr(8'h04, 32'h0);
        slow <= 1'b0;
        stall <= 1'b1;
        rx(2'd1, 8'h11, 4'h0);
        rx(2'd1, 8'h22, 4'h0);
        stall <= 1'b0;
        wait_post(1'b0, 2'd1, 16'h2221);
        // the model counts the last post at the edge this task returns on
        @(posedge hclk);
        chk32(32'(smps_chan_model_inst.posts - p0), 32'h5);
    endtask

    task automatic t_auto_in();
        wr(8'h00, 32'h0004);
        rx(2'd0, 8'h62, 4'h0);
        wait_post(1'b1, 2'd0, 16'h0062);
        rd_chk(8'h00, 32'h0004, 32'hFFFF_FFFF);
        rx(2'd0, 8'h63, 4'h4);
        wait_post(1'b0, 2'd0, 16'h6305);
        wr(8'h00, 32'h0004);
        rx(2'd0, 8'h64, 4'hC);
        wait_post(1'b0, 2'd0, 16'h5A05);
        wr(8'h00, 32'h000C);
        rx_special <= 1'b1;
        rx(2'd0, 8'h65, 4'h0);
        rx_special <= 1'b0;
        wait_post(1'b0, 2'd0, 16'h650D);
    endtask

    task automatic t_echo();
        int e0;
        wr(8'h18, 32'h0006);
        e0 = echo_cnt;
        rx(2'd3, 8'h35, 4'h0);
        wait_post(1'b1, 2'd3, 16'h0035);
        repeat (2) @(posedge hclk);
        chk32(32'(echo_cnt - e0), 32'h1);
        out_busy[3] <= 1'b1;
        rx(2'd3, 8'h33, 4'h0);
        wait_post(1'b0, 2'd3, 16'h3347);
        repeat (2) @(posedge hclk);
        chk32(32'(echo_cnt - e0), 32'h1);
        wr(8'h80, 32'h1);
        wr(8'h18, 32'h0006);
        rx(2'd3, 8'h34, 4'h0);
        wait_post(1'b0, 2'd3, 16'h3487);
        out_busy[3] <= 1'b0;
        wr(8'h80, 32'h0);
    endtask

    task automatic t_output();
        int i2;
        i2 = irq_cnt[2];
        wr(8'h14, 32'h0006);
        // the write lands on the edge wr returns at; let it settle
        @(posedge hclk);
        chk1(tx_allow[2], 1'b1);
        tx_evt(0, 2);
        rd_chk(8'h14, 32'h0007, 32'hFFFF_FFFF);
        chk1(tx_allow[2], 1'b0);
        chk32(32'(irq_cnt[2] - i2), 32'h1);
        wr(8'h14, 32'h0004);
        tx_evt(0, 2);
        rd_chk(8'h14, 32'h0005, 32'hFFFF_FFFF);
        wr(8'h14, 32'h0002);
        tx_evt(0, 2);
        rd_chk(8'h14, 32'h0002, 32'hFFFF_FFFF);
        tx_evt(1, 2);
        rd_chk(8'h14, 32'h0003, 32'hFFFF_FFFF);
        i2 = irq_cnt[2];
        dev_status[2] <= 1'b1;
        repeat (3) @(posedge hclk);
        rd_chk(8'h14, 32'h0091, 32'h0091);
        chk32(32'(irq_cnt[2] - i2), 32'h0);
        wr(8'h14, 32'h0010);
        dev_status[2] <= 1'b0;
        repeat (3) @(posedge hclk);
        rd_chk(8'h14, 32'h0081, 32'h0091);
        chk32(32'(irq_cnt[2] - i2), 32'h1);
        wr(8'h1C, 32'h000A);
        tx_evt(2, 3);
        rd_chk(8'h1C, 32'h0001, 32'h0001);
        chk1(tx_allow[3], 1'b0);
    endtask

    initial
    begin
        {hresetn, hsel, hwrite, rx_valid, rx_parity_err, rx_no_stop} = 6'h0;
        {rx_special, rx_buf_full, rx_mid_word, stall, slow} = 5'h0;
        {haddr, htrans, hsize, hwdata} = 45'h0;
        {rx_port, rx_char, rx_last_byte} = {2'h0, 8'h00, 8'h5A};
        {out_busy, tx_fetch, tx_last, tx_special_sent, dev_status} = 20'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_receive();
        t_auto_in();
        t_echo();
        t_output();
        stop_test();
    end
    initial
    begin
        #200000;
        hang();
    end
endmodule // tb_top
